// >>> hw/cmp_ctrl_regs.svh
`ifndef CMP_CTRL_REGS_SVH
`define CMP_CTRL_REGS_SVH
`define CMP1_CTRL_ADDR 8'h9a
`define CMP0_CTRL_ADDR 8'h9b
`define CMP1_MODE_ADDR 8'h9c
`define CMP0_MODE_ADDR 8'h9d
`define BIT_ENABLE 7
`define BIT_OUT_STATE 6
`define BIT_RISE_FLAG 5
`define BIT_FALL_FLAG 4
`define BIT_RISE_IE 5
`define BIT_FALL_IE 4
`define POS_HYS_MSB 3
`define POS_HYS_LSB 2
`define NEG_HYS_MSB 1
`define NEG_HYS_LSB 0
`define RESP_MSB 1
`define RESP_LSB 0
`define CTRL_RESET 8'h00
`define MODE_RESET 2'h2
`define SYNC_STAGES 2
`endif

// >>> hw/cmp_ctrl_pkg.sv
package cmp_ctrl_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [1:0] field2_t;
endpackage : cmp_ctrl_pkg

// >>> hw/cmp_sync_edge.sv
`timescale 1ns/10ps
`include "cmp_ctrl_regs.svh"
module cmp_sync_edge (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic rawIn,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic last_r;
   // ************************************************
   // Two-stage synchroniser and edge detection.
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= rawIn;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end
   assign level = sync_r;
   assign rise = sync_r & ~last_r;
   assign fall = ~sync_r & last_r;
endmodule : cmp_sync_edge

// >>> hw/dual_comparator_control.sv
// What this block does
// - Bit 6 of each control register reads the synchronised comparator output, 1 when plus exceeds minus.
// - Bit 5 of comparator 0's control register is a rising-edge flag that stays set until software writes 0.
// - Bit 4 of comparator 0's control register is a falling-edge flag that stays set until software writes 0.
// - Comparator 1 has the same flags, output bit, enable and hysteresis fields in its own control register.
// - Bits 3 to 2 hold the positive hysteresis code driven to the analog core, 00 meaning off.
// - Bits 1 to 0 hold the negative hysteresis code with the same encoding.
// - Bit 5 of each mode register enables the rising-edge interrupt.
// - Bit 4 of each mode register enables the falling-edge interrupt.
// - Bits 1 to 0 of each mode register hold the response mode forwarded to the analog core.
// - Mode register bits 7 to 6 and 3 to 2 read zero and ignore writes.
// - Registers decode at 0x9B, 0x9D, 0x9A and 0x9C regardless of register page.
// - Bit 7 of each control register enables the comparator and resets to 0.
// - A low-to-high output change sets the rising flag and a high-to-low change sets the falling flag.
// - A disabled comparator has its supply switched off at once and its port output forced low from the next cycle.
`timescale 1ns/10ps
`include "cmp_ctrl_regs.svh"
module dual_comparator_control (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire cmp_ctrl_pkg::byte_t sfrAddr,
   input wire cmp_ctrl_pkg::byte_t sfrWrData,
   input wire logic sfrWrEn,
   input wire logic sfrRdEn,
   output cmp_ctrl_pkg::byte_t sfrRdData,
   input wire logic [1:0] cmpRaw,
   output logic [1:0] cmpPowerOn,
   output logic [1:0] cmpPortOut,
   output cmp_ctrl_pkg::field2_t cmp0PosHys,
   output cmp_ctrl_pkg::field2_t cmp0NegHys,
   output cmp_ctrl_pkg::field2_t cmp1PosHys,
   output cmp_ctrl_pkg::field2_t cmp1NegHys,
   output cmp_ctrl_pkg::field2_t cmp0Resp,
   output cmp_ctrl_pkg::field2_t cmp1Resp,
   output logic [1:0] cmpIrq
);
   import cmp_ctrl_pkg::*;
   // ************************************************
   // Declarations.
   // ************************************************
   logic [1:0] enable_r;
   logic [1:0] riseFlag_r;
   logic [1:0] fallFlag_r;
   logic [1:0] riseIe_r;
   logic [1:0] fallIe_r;
   field2_t posHys_r [2];
   field2_t negHys_r [2];
   field2_t resp_r [2];
   logic [1:0] irq_r;
   logic [1:0] portOut_r;
   byte_t rdData_r;
   logic [1:0] level;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] ctrlWr;
   logic [1:0] modeWr;
   byte_t ctrlView [2];
   byte_t modeView [2];
   byte_t rdData_nxt;
   // ************************************************
   // Address decode.
   // ************************************************
   logic selCtrl0;
   logic selCtrl1;
   logic selMode0;
   logic selMode1;
   // Each register answers on every page because only the address is compared.
   assign selCtrl0 = (sfrAddr == `CMP0_CTRL_ADDR);
   assign selCtrl1 = (sfrAddr == `CMP1_CTRL_ADDR);
   assign selMode0 = (sfrAddr == `CMP0_MODE_ADDR);
   assign selMode1 = (sfrAddr == `CMP1_MODE_ADDR);
   assign ctrlWr[0] = sfrWrEn && selCtrl0;
   assign ctrlWr[1] = sfrWrEn && selCtrl1;
   assign modeWr[0] = sfrWrEn && selMode0;
   assign modeWr[1] = sfrWrEn && selMode1;
   // ************************************************
   // Per-comparator logic.
   // ************************************************
   for (genvar i = 0; i < 2; i++) begin : g_cmp
      // ************************************************
      // Synchroniser.
      // ************************************************
      cmp_sync_edge u_sync (
         .clk_sys(clk_sys),
         .sys_rst(sys_rst),
         .rawIn(cmpRaw[i]),
         .level(level[i]),
         .rise(rise[i]),
         .fall(fall[i])
      );
      logic enable_nxt;
      logic riseFlag_nxt;
      logic fallFlag_nxt;
      logic riseHeld;
      logic fallHeld;
      logic riseIe_nxt;
      logic fallIe_nxt;
      field2_t posHys_nxt;
      field2_t negHys_nxt;
      field2_t resp_nxt;
      logic irq_nxt;
      logic portOut_nxt;
      // ************************************************
      // Register views for readback.
      // ************************************************
      assign ctrlView[i] = {enable_r[i], level[i], riseFlag_r[i], fallFlag_r[i], posHys_r[i], negHys_r[i]};
      assign modeView[i] = {2'h0, riseIe_r[i], fallIe_r[i], 2'h0, resp_r[i]};
      // ************************************************
      // Control register next values.
      // ************************************************
      assign enable_nxt = ctrlWr[i] ? sfrWrData[`BIT_ENABLE] : enable_r[i];
      assign posHys_nxt = ctrlWr[i] ? sfrWrData[`POS_HYS_MSB:`POS_HYS_LSB] : posHys_r[i];
      assign negHys_nxt = ctrlWr[i] ? sfrWrData[`NEG_HYS_MSB:`NEG_HYS_LSB] : negHys_r[i];
      // A write replaces a flag, otherwise the flag keeps its value.
      assign riseHeld = ctrlWr[i] ? sfrWrData[`BIT_RISE_FLAG] : riseFlag_r[i];
      assign fallHeld = ctrlWr[i] ? sfrWrData[`BIT_FALL_FLAG] : fallFlag_r[i];
      // A hardware edge wins over a software clear in the same cycle.
      assign riseFlag_nxt = rise[i] | riseHeld;
      assign fallFlag_nxt = fall[i] | fallHeld;
      // ************************************************
      // Mode register next values.
      // ************************************************
      assign riseIe_nxt = modeWr[i] ? sfrWrData[`BIT_RISE_IE] : riseIe_r[i];
      assign fallIe_nxt = modeWr[i] ? sfrWrData[`BIT_FALL_IE] : fallIe_r[i];
      assign resp_nxt = modeWr[i] ? sfrWrData[`RESP_MSB:`RESP_LSB] : resp_r[i];
      // ************************************************
      // Output next values.
      // ************************************************
      assign irq_nxt = (riseFlag_r[i] & riseIe_r[i]) | (fallFlag_r[i] & fallIe_r[i]);
      // The registered port output goes low one cycle after the comparator is switched off.
      assign portOut_nxt = enable_r[i] & level[i];
      // ************************************************
      // Control registers.
      // ************************************************
      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            enable_r[i] <= 1'b0;
            posHys_r[i] <= 2'h0;
            negHys_r[i] <= 2'h0;
         end else begin
            enable_r[i] <= enable_nxt;
            posHys_r[i] <= posHys_nxt;
            negHys_r[i] <= negHys_nxt;
         end
      end
      // ************************************************
      // Edge flags.
      // ************************************************
      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            riseFlag_r[i] <= 1'b0;
            fallFlag_r[i] <= 1'b0;
         end else begin
            riseFlag_r[i] <= riseFlag_nxt;
            fallFlag_r[i] <= fallFlag_nxt;
         end
      end
      // ************************************************
      // Mode registers.
      // ************************************************
      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            riseIe_r[i] <= 1'b0;
            fallIe_r[i] <= 1'b0;
            resp_r[i] <= `MODE_RESET;
         end else begin
            riseIe_r[i] <= riseIe_nxt;
            fallIe_r[i] <= fallIe_nxt;
            resp_r[i] <= resp_nxt;
         end
      end
      // ************************************************
      // Interrupt and port registers.
      // ************************************************
      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            irq_r[i] <= 1'b0;
            portOut_r[i] <= 1'b0;
         end else begin
            irq_r[i] <= irq_nxt;
            portOut_r[i] <= portOut_nxt;
         end
      end
   end
   // ************************************************
   // Read mux.
   // ************************************************
   always_comb begin
      rdData_nxt = 8'h00;
      if (selCtrl0) begin
         rdData_nxt = ctrlView[0];
      end else if (selCtrl1) begin
         rdData_nxt = ctrlView[1];
      end else if (selMode0) begin
         rdData_nxt = modeView[0];
      end else if (selMode1) begin
         rdData_nxt = modeView[1];
      end
   end
   // ************************************************
   // Read data register.
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdData_r <= `CTRL_RESET;
      end else if (sfrRdEn) begin
         rdData_r <= rdData_nxt;
      end
   end
   // ************************************************
   // Outputs.
   // ************************************************
   assign sfrRdData = rdData_r;
   assign cmpPowerOn = enable_r;
   assign cmpPortOut = portOut_r;
   assign cmp0PosHys = posHys_r[0];
   assign cmp0NegHys = negHys_r[0];
   assign cmp1PosHys = posHys_r[1];
   assign cmp1NegHys = negHys_r[1];
   assign cmp0Resp = resp_r[0];
   assign cmp1Resp = resp_r[1];
   assign cmpIrq = irq_r;
endmodule : dual_comparator_control

// >>> dv/cmp_ctrl_monitor.sv
`timescale 1ns/10ps
// ****************
// Port checker.
// ****************
module cmp_ctrl_monitor (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic sfrWrEn,
   input wire logic sfrRdEn,
   input wire cmp_ctrl_pkg::byte_t sfrAddr,
   input wire cmp_ctrl_pkg::byte_t sfrWrData,
   input wire cmp_ctrl_pkg::byte_t sfrRdData,
   input wire logic [1:0] cmpRaw,
   input wire logic [1:0] cmpPowerOn,
   input wire logic [1:0] cmpPortOut,
   input wire logic [1:0] cmpIrq,
   input wire cmp_ctrl_pkg::field2_t cmp0PosHys,
   input wire cmp_ctrl_pkg::field2_t cmp0NegHys,
   input wire cmp_ctrl_pkg::field2_t cmp0Resp,
   input wire cmp_ctrl_pkg::field2_t cmp1Resp
);
   import cmp_ctrl_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_wr0(a); sfrWrEn && sfrAddr == a; endsequence
   sequence s_rise0; (cmpPowerOn[0] && $rose(cmpRaw[0])) ##1 (cmpPowerOn[0] && cmpRaw[0]) [*3]; endsequence
   a_power_enable: assert property (s_wr0(8'h9b) |=> cmpPowerOn[0] == $past(sfrWrData[7])) else $error("bad en");
   a_hys_drive: assert property (s_wr0(8'h9b) |=> {cmp0PosHys, cmp0NegHys} == $past(sfrWrData[3:0]))
      else $error("bad hysteresis");
   a_resp_drive: assert property (s_wr0(8'h9d) |=> cmp0Resp == $past(sfrWrData[1:0])) else $error("bad mode");
   a_mode_unused: assert property (sfrRdEn && sfrAddr == 8'h9d |=> (sfrRdData & 8'hcc) == 8'h00)
      else $error("mode unused bits set");
   a_unmapped_zero: assert property (sfrRdEn && (sfrAddr < 8'h9a || sfrAddr > 8'h9d) |=> sfrRdData == 8'h00)
      else $error("unmapped read not zero");
   a_port_rise: assert property (s_rise0 |-> cmpPortOut[0]) else $error("port late");
   a_port_off: assert property (!cmpPowerOn[0] && !$past(cmpPowerOn[0]) |-> !cmpPortOut[0]) else $error("port on");
   a_reset_vals: assert property ($fell(sys_rst) |-> cmpIrq == 2'h0 && cmpPowerOn == 2'h0 && cmp1Resp == 2'h2)
      else $error("bad reset values");
endmodule : cmp_ctrl_monitor
bind dual_comparator_control cmp_ctrl_monitor u_mon (.*);

// >>> dv/cmp_analog_model.sv
`timescale 1ns/10ps
// ****************
// Analog cores: output follows the inputs while powered.
// ****************
module cmp_analog_model (
   input wire logic [1:0] aboveIn,
   input wire logic [1:0] cmpPowerOn,
   output logic [1:0] cmpRaw
);
   initial cmpRaw = 2'h0;
   always @(aboveIn or cmpPowerOn) cmpRaw <= #7 aboveIn & cmpPowerOn;
endmodule : cmp_analog_model

// >>> dv/tb_top.sv
`timescale 1ns/10ps
// ****************
// Bench.
// ****************
module tb_top;
   import cmp_ctrl_pkg::*;
   logic clk_sys = 0, sys_rst = 1, sfrWrEn = 0, sfrRdEn = 0;
   byte_t sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData, rd;
   logic [1:0] above = 2'h0, cmpRaw, cmpPowerOn, cmpPortOut, cmpIrq;
   field2_t cmp0PosHys, cmp0NegHys, cmp1PosHys, cmp1NegHys, cmp0Resp, cmp1Resp;
   int n_mismatch = 0, tests_run = 0;
   logic [31:0] seed = 32'hc739_5ff5;
   byte_t addrs [4] = '{8'h9b, 8'h9a, 8'h9d, 8'h9c};
   always #20 clk_sys = ~clk_sys;
   dual_comparator_control u_dut (.*);
   cmp_analog_model u_model (.aboveIn(above), .*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic byte_t expRd(input byte_t a, input byte_t d);
      return (a > 8'h9b) ? (d & 8'h33) : (d & 8'hbf);
   endfunction : expRd
   task automatic chk(input byte_t got, input byte_t exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic op(input logic w, input byte_t a, input byte_t d);
      @(negedge clk_sys);
      {sfrAddr, sfrWrData, sfrWrEn, sfrRdEn} = {a, d, w, !w};
      @(negedge clk_sys);
      {sfrWrEn, sfrRdEn} = 2'h0;
      rd = sfrRdData;
   endtask : op
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   initial begin
      repeat (4) @(negedge clk_sys);
      sys_rst = 0;
      foreach (addrs[i]) begin
         op(0, addrs[i], 8'h00);
         chk(rd, i < 2 ? 8'h00 : 8'h02);
      end
      repeat (12) begin
         seed = lfsr(seed);
         foreach (addrs[i]) begin
            op(1, addrs[i], seed[7:0]);
            op(0, addrs[i], 8'h00);
            chk(rd, expRd(addrs[i], seed[7:0]));
         end
         chk({cmp0PosHys, cmp0NegHys, cmp1PosHys, cmp1NegHys}, {2{seed[3:0]}});
         chk({2'h0, cmp0Resp, cmp1Resp, cmpPowerOn}, {2'h0, {2{seed[1:0]}}, {2{seed[7]}}});
      end
      op(1, 8'h9e, 8'hff);
      op(0, 8'h9e, 8'h00);
      chk(rd, 8'h00);
      op(1, 8'h9d, 8'h30);
      op(1, 8'h9c, 8'h10);
      op(1, 8'h9b, 8'h80);
      op(1, 8'h9a, 8'h80);
      above = 2'h3;
      repeat (8) @(negedge clk_sys);
      op(0, 8'h9b, 8'h00);
      chk(rd, 8'he0);
      chk({4'h0, cmpIrq, cmpPortOut}, 8'h07);
      above = 2'h0;
      repeat (8) @(negedge clk_sys);
      op(0, 8'h9a, 8'h00);
      chk(rd, 8'hb0);
      chk({4'h0, cmpIrq, cmpPortOut}, 8'h0c);
      op(1, 8'h9b, 8'h80);
      op(0, 8'h9b, 8'h00);
      chk(rd, 8'h80);
      op(1, 8'h9a, 8'h00);
      above = 2'h3;
      repeat (8) @(negedge clk_sys);
      chk({4'h0, cmpIrq, cmpPortOut}, 8'h05);
      test_done();
   end
   initial begin
      #(40 * 2000);
      n_mismatch++;
      test_done();
   end
endmodule : tb_top
